// file: core/card_slot_control_status.sv
// Operation
// - status bit 7 shows card active
// - bit 6 latches early answer, read clears
// - bit 5 latches missing answer, read clears
// - bit 4 latches session overload, read clears
// - bit 3 latches supervisor fault, read clears
// - bit 2 shows fallback clock in power-down
// - bit 1 latches insertion or removal, read clears
// - bit 0 shows card present
// - low select forces 1.8 V, else 5/3 V
// - voltage bits locked while start is set
// - io connect links host and card pins
// - park select picks parked or divided clock
// - park bit locked in sync mode while started
// - writing warm bit while start is set starts warm reset
// - warm bit drops on start bit or mute
// - start begins activation only when fault-free, present
// - writing start zero begins deactivation
// - interrupt low while any latched flag stands
// - view field picks second register view
// - page select 01h/02h picks slot
//
// card slot control and status registers for the main card slots
// assumes a decoded byte register port, synchronous card side inputs,
// and external pull-ups on the open-drain io pins
`timescale 1ns/1ps
module card_slot_control_status #(
  parameter int NUM_SLOTS = 2,
  parameter logic [slot_regs_pkg::SEQ_CNT_W-1:0] ACT_CYCLES = slot_regs_pkg::ACT_CYCLES_DEF,
  parameter logic [slot_regs_pkg::SEQ_CNT_W-1:0] DEACT_CYCLES = slot_regs_pkg::DEACT_CYCLES_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [slot_regs_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [slot_regs_pkg::DATA_W-1:0] reg_wdata_i,
  output logic [slot_regs_pkg::DATA_W-1:0] reg_rdata_o,
  output logic interrupt_out_n_o,
  // per-slot card side status inputs
  input wire logic [NUM_SLOTS-1:0] card_inserted_level_i,
  input wire logic [NUM_SLOTS-1:0] atr_early_i,
  input wire logic [NUM_SLOTS-1:0] atr_mute_i,
  input wire logic [NUM_SLOTS-1:0] overload_i,
  input wire logic [NUM_SLOTS-1:0] supervisor_fault_i,
  input wire logic [NUM_SLOTS-1:0] fallback_clock_i,
  input wire logic [NUM_SLOTS-1:0] card_start_bit_i,
  input wire logic [NUM_SLOTS-1:0] sync_mode_i,
  // per-slot controls
  output logic [2*NUM_SLOTS-1:0] vcc_sel_o,
  output logic [NUM_SLOTS-1:0] card_active_o,
  output logic [NUM_SLOTS-1:0] clock_park_select_o,
  output logic [2*NUM_SLOTS-1:0] view_select_o,
  output logic [NUM_SLOTS-1:0] warm_reset_o,
  // open-drain io pins, oe low means driving low
  input wire logic [NUM_SLOTS-1:0] host_io_pin_i,
  output logic [NUM_SLOTS-1:0] host_io_pin_o,
  output logic [NUM_SLOTS-1:0] host_io_pin_oe_n_o,
  input wire logic [NUM_SLOTS-1:0] card_io_pin_i,
  output logic [NUM_SLOTS-1:0] card_io_pin_o,
  output logic [NUM_SLOTS-1:0] card_io_pin_oe_n_o
);
  import slot_regs_pkg::*;

  logic [DATA_W-1:0] page_select; // selected bank page
  logic [NUM_SLOTS-1:0] slot_sel; // page decode per slot
  logic [NUM_SLOTS-1:0] slot_irq; // any latched flag per slot
  logic [DATA_W-1:0] slot_status [NUM_SLOTS]; // live status byte per slot

  // address decode
  wire hit_reg0 = (reg_addr_i == SLOT_REG0_ADDR);
  wire hit_page = (reg_addr_i == PAGE_SEL_ADDR);

  // page select register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      page_select <= PAGE_SEL_RESET;
    end else if (reg_wr_i & hit_page) begin
      page_select <= reg_wdata_i;
    end
  end

  // read data mux; unmapped pages and addresses read as zero
  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    if (hit_page) begin
      next_rdata = page_select;
    end else if (hit_reg0) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        if (slot_sel[i]) begin
          next_rdata = slot_status[i];
        end
      end
    end
  end

  // read data held until the next read
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // interrupt, low while any slot holds a latched flag
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      interrupt_out_n_o <= 1'b1;
    end else begin
      interrupt_out_n_o <= ~(|slot_irq);
    end
  end

  genvar s;
  generate
    for (s = 0; s < NUM_SLOTS; s++) begin : g_slot
      localparam logic [DATA_W-1:0] MY_PAGE = PAGE_SLOT_BASE + DATA_W'(s);

      slot_state_e state; // session sequencer
      slot_state_e next_state;
      logic [SEQ_CNT_W-1:0] seq_cnt; // step timer
      logic present_q; // presence one cycle ago
      logic [NUM_FLAGS-1:0] flags; // latched events
      logic [NUM_FLAGS-1:0] flag_set; // events this cycle
      logic low_v, high_v, io_conn, park, warm_req, start_req;
      logic [1:0] view;

      // this slot is reached when the page matches
      assign slot_sel[s] = (page_select == MY_PAGE);
      wire ctrl_wr = reg_wr_i & hit_reg0 & slot_sel[s];
      wire status_rd = reg_rd_i & hit_reg0 & slot_sel[s];

      // session phases
      wire in_session = (state != SLOT_IDLE);
      wire powered = (state == SLOT_ACTIVATING) | (state == SLOT_ACTIVE);

      // events feeding the sticky flags
      wire card_inserted_level_change = card_inserted_level_i[s] ^ present_q;
      assign flag_set[FL_CHANGE] = card_inserted_level_change;
      assign flag_set[FL_SUPPLY] = supervisor_fault_i[s];
      assign flag_set[FL_OVERLOAD] = overload_i[s] & in_session;
      assign flag_set[FL_MUTE] = atr_mute_i[s] & powered;
      assign flag_set[FL_EARLY] = atr_early_i[s] & powered;

      // presence history for change detection
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          present_q <= 1'b0;
        end else begin
          present_q <= card_inserted_level_i[s];
        end
      end

      // flags cleared by a status read of this slot, new events kept
      sticky_flag_bank #(
        .WIDTH(NUM_FLAGS),
        .RESET_VAL(FLAGS_RESET)
      ) u_flags (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .set_i(flag_set),
        .clear_i(status_rd),
        .flags_o(flags)
      );

      assign slot_irq[s] = |flags;

      // status byte assembly
      always_comb begin
        slot_status[s] = '0;
        slot_status[s][ST_ACTIVE] = powered;
        slot_status[s][ST_EARLY] = flags[FL_EARLY];
        slot_status[s][ST_MUTE] = flags[FL_MUTE];
        slot_status[s][ST_OVERLOAD] = flags[FL_OVERLOAD];
        slot_status[s][ST_SUPPLY] = flags[FL_SUPPLY];
        slot_status[s][ST_FALLBACK] = fallback_clock_i[s];
        slot_status[s][ST_CHANGE] = flags[FL_CHANGE];
        slot_status[s][ST_PRESENT] = card_inserted_level_i[s];
      end

      // start allowed only with no supply or overload flag and a card in place
      wire start_ok = ~flags[FL_SUPPLY] & ~flags[FL_OVERLOAD] & card_inserted_level_i[s];
      // faults and card removal end the session without software
      wire hw_stop = in_session & (overload_i[s] | supervisor_fault_i[s] | ~card_inserted_level_i[s]);
      wire warm_done = card_start_bit_i[s] | flag_set[FL_MUTE];

      slot_control_reg u_ctrl (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .wr_i(ctrl_wr),
        .wdata_i(reg_wdata_i),
        .start_ok_i(start_ok),
        .sync_mode_i(sync_mode_i[s]),
        .hw_stop_i(hw_stop),
        .warm_done_i(warm_done),
        .low_voltage_select_o(low_v),
        .high_voltage_select_o(high_v),
        .io_connect_o(io_conn),
        .view_select_o(view),
        .clock_park_select_o(park),
        .warm_req_o(warm_req),
        .start_req_o(start_req)
      );

      // sequencer next state; timer runs out at the step length
      wire act_done = (seq_cnt == ACT_CYCLES - 1'b1);
      wire deact_done = (seq_cnt == DEACT_CYCLES - 1'b1);
      always_comb begin
        next_state = state;
        case (state)
          SLOT_IDLE: begin
            if (start_req) begin
              next_state = SLOT_ACTIVATING;
            end
          end
          SLOT_ACTIVATING: begin
            if (!start_req) begin
              next_state = SLOT_DEACTIVATING;
            end else if (act_done) begin
              next_state = SLOT_ACTIVE;
            end
          end
          SLOT_ACTIVE: begin
            if (!start_req) begin
              next_state = SLOT_DEACTIVATING;
            end
          end
          SLOT_DEACTIVATING: begin
            if (deact_done) begin
              next_state = SLOT_IDLE;
            end
          end
          default: begin
            next_state = SLOT_IDLE;
          end
        endcase
      end

      // sequencer state and step timer
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          state <= SLOT_IDLE;
          seq_cnt <= '0;
        end else begin
          state <= next_state;
          seq_cnt <= (next_state != state) ? '0 : seq_cnt + 1'b1;
        end
      end

      // supply code; off outside a powered session
      wire [1:0] next_vcc = !powered ? VCC_OFF :
                            low_v ? VCC_1V8 :
                            high_v ? VCC_5V : VCC_3V;

      // open-drain pass-through, one side at a time drives low;
      // registered, so a one-cycle lag is traded for clean flop outputs
      wire next_card_low = io_conn & ~host_io_pin_i[s] & host_io_pin_oe_n_o[s];
      wire next_host_low = io_conn & ~card_io_pin_i[s] & card_io_pin_oe_n_o[s];

      // slot outputs
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          vcc_sel_o[2*s +: 2] <= VCC_OFF;
          card_active_o[s] <= 1'b0;
          clock_park_select_o[s] <= 1'b0;
          view_select_o[2*s +: 2] <= 2'h0;
          warm_reset_o[s] <= 1'b0;
          card_io_pin_oe_n_o[s] <= 1'b1;
          host_io_pin_oe_n_o[s] <= 1'b1;
        end else begin
          vcc_sel_o[2*s +: 2] <= next_vcc;
          card_active_o[s] <= powered;
          clock_park_select_o[s] <= park;
          view_select_o[2*s +: 2] <= view;
          warm_reset_o[s] <= warm_req;
          card_io_pin_oe_n_o[s] <= ~(next_card_low & ~next_host_low);
          host_io_pin_oe_n_o[s] <= ~(next_host_low & ~next_card_low);
        end
      end

      // driven level is always low; the pull-up gives the high
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          card_io_pin_o[s] <= 1'b0;
          host_io_pin_o[s] <= 1'b0;
        end else begin
          card_io_pin_o[s] <= 1'b0;
          host_io_pin_o[s] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule // card_slot_control_status

// file: core/slot_regs_pkg.sv
// constants shared by the card slot control and status block
// assumes one byte-wide register port already decoded from the serial host link
package slot_regs_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register addresses on the byte port
  localparam logic [ADDR_W-1:0] SLOT_REG0_ADDR = 8'h40; // status on read, control on write
  localparam logic [ADDR_W-1:0] PAGE_SEL_ADDR = 8'h48; // page select byte

  // page select values
  localparam logic [DATA_W-1:0] PAGE_SLOT_BASE = 8'h01; // slot 1, next slot follows
  localparam logic [DATA_W-1:0] PAGE_SEL_RESET = 8'h00;

  // status byte bit positions
  localparam int ST_ACTIVE = 7;
  localparam int ST_EARLY = 6;
  localparam int ST_MUTE = 5;
  localparam int ST_OVERLOAD = 4;
  localparam int ST_SUPPLY = 3;
  localparam int ST_FALLBACK = 2;
  localparam int ST_CHANGE = 1;
  localparam int ST_PRESENT = 0;

  // sticky flag vector layout: change, supply, overload, mute, early
  localparam int NUM_FLAGS = 5;
  localparam int FL_CHANGE = 0;
  localparam int FL_SUPPLY = 1;
  localparam int FL_OVERLOAD = 2;
  localparam int FL_MUTE = 3;
  localparam int FL_EARLY = 4;
  // supply fault flag stands after power-on until first status read
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 5'h02;

  // control byte bit positions
  localparam int CT_LOW_V = 7;
  localparam int CT_IO_CONNECT = 6;
  localparam int CT_VIEW_HI = 5;
  localparam int CT_VIEW_LO = 4;
  localparam int CT_PARK = 3;
  localparam int CT_HIGH_V = 2;
  localparam int CT_WARM = 1;
  localparam int CT_START = 0;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;

  // supply selection code driven to the regulator
  localparam logic [1:0] VCC_OFF = 2'h0;
  localparam logic [1:0] VCC_1V8 = 2'h1;
  localparam logic [1:0] VCC_3V = 2'h2;
  localparam logic [1:0] VCC_5V = 2'h3;

  // sequencing step lengths in cycles
  localparam int SEQ_CNT_W = 8;
  localparam logic [SEQ_CNT_W-1:0] ACT_CYCLES_DEF = 8'h10;
  localparam logic [SEQ_CNT_W-1:0] DEACT_CYCLES_DEF = 8'h10;

  // card session sequencer states
  typedef enum logic [1:0] {
    SLOT_IDLE,
    SLOT_ACTIVATING,
    SLOT_ACTIVE,
    SLOT_DEACTIVATING
  } slot_state_e;

endpackage

// file: core/sticky_flag_bank.sv
// bank of latched event flags cleared together by one read strobe
// assumes set and clear are synchronous to sys_clk_i
`timescale 1ns/1ps
module sticky_flag_bank #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] set_i,   // one-cycle event per flag
  input wire logic clear_i,             // status byte read
  output logic [WIDTH-1:0] flags_o      // latched flags
);

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_flag
      // set beats clear so an event during the read is kept
      wire next_flag = set_i[b] | (flags_o[b] & ~clear_i);
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          flags_o[b] <= RESET_VAL[b];
        end else begin
          flags_o[b] <= next_flag;
        end
      end
    end
  endgenerate

endmodule // sticky_flag_bank

// file: core/slot_control_reg.sv
// control byte of one slot with its write locks and self-clearing bits
// assumes the caller gates wr_i with address and page decode
`timescale 1ns/1ps
module slot_control_reg
  import slot_regs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wr_i,                                  // control byte write
  input wire logic [slot_regs_pkg::DATA_W-1:0] wdata_i,   // written byte
  input wire logic start_ok_i,                            // no faults and card present
  input wire logic sync_mode_i,                           // synchronous card mode
  input wire logic hw_stop_i,                             // emergency stop of the session
  input wire logic warm_done_i,                           // start bit seen or mute flagged
  output logic low_voltage_select_o,
  output logic high_voltage_select_o,
  output logic io_connect_o,
  output logic [1:0] view_select_o,
  output logic clock_park_select_o,
  output logic warm_req_o,
  output logic start_req_o
);

  // voltage and park locks look at start as it stood before the write
  wire volt_wr = wr_i & ~start_req_o;
  wire park_wr = wr_i & ~(sync_mode_i & start_req_o);
  wire start_set = wr_i & wdata_i[CT_START] & (start_req_o | start_ok_i);
  wire start_clr = hw_stop_i | (wr_i & ~wdata_i[CT_START]);
  wire warm_set = wr_i & wdata_i[CT_WARM] & start_req_o;

  // supply select bits
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_voltage_select_o <= CTRL_RESET[CT_LOW_V];
      high_voltage_select_o <= CTRL_RESET[CT_HIGH_V];
    end else if (volt_wr) begin
      low_voltage_select_o <= wdata_i[CT_LOW_V];
      high_voltage_select_o <= wdata_i[CT_HIGH_V];
    end
  end

  // io connect, view select and clock source
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      io_connect_o <= CTRL_RESET[CT_IO_CONNECT];
      view_select_o <= CTRL_RESET[CT_VIEW_HI:CT_VIEW_LO];
      clock_park_select_o <= CTRL_RESET[CT_PARK];
    end else begin
      if (wr_i) begin
        io_connect_o <= wdata_i[CT_IO_CONNECT];
        view_select_o <= wdata_i[CT_VIEW_HI:CT_VIEW_LO];
      end
      if (park_wr) begin
        clock_park_select_o <= wdata_i[CT_PARK];
      end
    end
  end

  // start request; a stop from hardware wins over everything
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_req_o <= CTRL_RESET[CT_START];
    end else if (start_clr) begin
      start_req_o <= 1'b0;
    end else if (start_set) begin
      start_req_o <= 1'b1;
    end
  end

  // warm reset request, dropped by hardware when the card answers or stays mute
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      warm_req_o <= CTRL_RESET[CT_WARM];
    end else if (warm_set) begin
      warm_req_o <= 1'b1;
    end else if (warm_done_i | ~start_req_o) begin
      warm_req_o <= 1'b0;
    end
  end

endmodule // slot_control_reg

// file: tb/slot_chk.sv
// concurrent checks on the slot register block, slot 1 seen through page 01h
// assumes it is bound onto card_slot_control_status
`timescale 1ns/1ps
module slot_chk
  import slot_regs_pkg::*;
#(
  parameter int NUM_SLOTS = 2,
  parameter logic [slot_regs_pkg::SEQ_CNT_W-1:0] ACT_CYCLES = slot_regs_pkg::ACT_CYCLES_DEF,
  parameter logic [slot_regs_pkg::SEQ_CNT_W-1:0] DEACT_CYCLES = slot_regs_pkg::DEACT_CYCLES_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [slot_regs_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [slot_regs_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic [slot_regs_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic interrupt_out_n_o,
  input wire logic [NUM_SLOTS-1:0] card_inserted_level_i,
  input wire logic [NUM_SLOTS-1:0] card_start_bit_i,
  input wire logic [NUM_SLOTS-1:0] sync_mode_i,
  input wire logic [2*NUM_SLOTS-1:0] vcc_sel_o,
  input wire logic [NUM_SLOTS-1:0] card_active_o,
  input wire logic [NUM_SLOTS-1:0] clock_park_select_o,
  input wire logic [2*NUM_SLOTS-1:0] view_select_o,
  input wire logic [NUM_SLOTS-1:0] warm_reset_o,
  input wire logic [NUM_SLOTS-1:0] card_io_pin_oe_n_o
);
  logic [DATA_W-1:0] page; // page as last written
  logic io_con; // slot 1 io connect as last written
  wire wr_page = reg_wr_i && (reg_addr_i == PAGE_SEL_ADDR);
  wire wr_reg0 = reg_wr_i && (reg_addr_i == SLOT_REG0_ADDR);
  wire wr_s1 = wr_reg0 && (page == PAGE_SLOT_BASE);
  wire wr_s2 = wr_reg0 && (page == PAGE_SLOT_BASE + 8'h01);
  wire wr_none = wr_reg0 && !wr_s1 && !wr_s2; // no slot selected
  wire rd_s1 = reg_rd_i && (reg_addr_i == SLOT_REG0_ADDR) && (page == PAGE_SLOT_BASE);
  // shadow copies, control byte is write-only
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      page <= PAGE_SEL_RESET;
      io_con <= 1'b0;
    end else begin
      if (wr_page) page <= reg_wdata_i;
      if (wr_s1) io_con <= reg_wdata_i[CT_IO_CONNECT];
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_start_try;
    wr_s1 && reg_wdata_i[CT_START] && !card_active_o[0];
  endsequence
  sequence s_stop;
    wr_s1 && !reg_wdata_i[CT_START] && card_active_o[0];
  endsequence
  property p_irq_reset; $past(rst_i) && !rst_i |-> ##[0:1] !interrupt_out_n_o; endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("irq not low after reset");
  property p_vcc_off; !card_active_o[0] |-> vcc_sel_o[1:0] == VCC_OFF; endproperty
  a_vcc_off: assert property (p_vcc_off) else $error("supply on while inactive");
  property p_start_ref; s_start_try ##0 !card_inserted_level_i[0] |=> !card_active_o[0] [*4]; endproperty
  a_start_ref: assert property (p_start_ref) else $error("start taken without card");
  property p_stop; s_stop |-> ##[1:4] !card_active_o[0]; endproperty
  a_stop: assert property (p_stop) else $error("no deactivation");
  property p_view1; wr_s1 |=> ##1 view_select_o[1:0] == $past(reg_wdata_i[CT_VIEW_HI:CT_VIEW_LO], 2); endproperty
  a_view1: assert property (p_view1) else $error("slot 1 view wrong");
  property p_view2; wr_s2 |=> ##1 view_select_o[3:2] == $past(reg_wdata_i[CT_VIEW_HI:CT_VIEW_LO], 2); endproperty
  a_view2: assert property (p_view2) else $error("slot 2 view wrong");
  property p_page_off; wr_none |=> ##1 $stable(view_select_o); endproperty
  a_page_off: assert property (p_page_off) else $error("write with no page took");
  property p_park; wr_s1 && !sync_mode_i[0] |=> ##1 clock_park_select_o[0] == $past(reg_wdata_i[CT_PARK], 2);
  endproperty
  a_park: assert property (p_park) else $error("park bit wrong");
  property p_park_lock; wr_s1 && sync_mode_i[0] && card_active_o[0] |=> ##1 $stable(clock_park_select_o[0]); endproperty
  a_park_lock: assert property (p_park_lock) else $error("park bit not locked");
  property p_warm; warm_reset_o[0] && card_start_bit_i[0] && !wr_reg0 |-> ##[1:2] !warm_reset_o[0]; endproperty
  a_warm: assert property (p_warm) else $error("warm not cleared");
  property p_present; rd_s1 |=> reg_rdata_o[ST_PRESENT] == $past(card_inserted_level_i[0]); endproperty
  a_present: assert property (p_present) else $error("present bit wrong");
  property p_io_off; !io_con [*3] |-> card_io_pin_oe_n_o[0]; endproperty
  a_io_off: assert property (p_io_off) else $error("card io driven while off");
endmodule // slot_chk

// file: tb/host_port_model.sv
// host side of the byte register port, tasks called from the bench
// assumes read data loads on the edge that takes the read strobe
`timescale 1ns/1ps
module host_port_model
  import slot_regs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic [slot_regs_pkg::DATA_W-1:0] rdata_i,
  output logic [slot_regs_pkg::ADDR_W-1:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [slot_regs_pkg::DATA_W-1:0] wdata_o
);
  // idle port at time zero
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // strobe held across exactly one rising edge, changed on falling edges
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(negedge sys_clk_i);
    addr_o = a;
    wdata_o = v;
    wr_o = 1'b1;
    @(negedge sys_clk_i);
    wr_o = 1'b0;
    wdata_o = ~v; // stale data scrambled
  endtask
  // data taken after the edge that took the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(negedge sys_clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge sys_clk_i);
    rd_o = 1'b0;
    v = rdata_i;
  endtask
endmodule // host_port_model

// file: tb/testbench.sv
// self-checking bench for the card slot register block
// assumes short activation counts; card side inputs driven on falling edges
`timescale 1ns/1ps
module testbench;
  import slot_regs_pkg::*;
  logic sys_clk_i, rst_i;
  wire [ADDR_W-1:0] addr;
  wire wr, rd, irq_n;
  wire [DATA_W-1:0] wdata, rdata;
  logic [1:0] present, early, mute, ovl, sup, fback, sbit, sync, host_drv; // card side stimulus
  wire [3:0] vcc, view;
  wire [1:0] active, park, warm, h_o, h_oe_n, c_o, c_oe_n;
  wire [1:0] host_pin = host_drv & h_oe_n; // pulled up, low when anyone drives
  wire [1:0] card_pin = c_oe_n; // idle card, pulled up
  int errors, total_checks, cycles;
  logic [7:0] d;
  logic [7:0] vset [3] = '{8'h81, 8'h05, 8'h01};
  logic [1:0] vexp [3] = '{VCC_1V8, VCC_5V, VCC_3V};
  card_slot_control_status #(.NUM_SLOTS(2), .ACT_CYCLES(8'h02), .DEACT_CYCLES(8'h02)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .interrupt_out_n_o(irq_n),
    .card_inserted_level_i(present), .atr_early_i(early), .atr_mute_i(mute), .overload_i(ovl),
    .supervisor_fault_i(sup), .fallback_clock_i(fback), .card_start_bit_i(sbit), .sync_mode_i(sync),
    .vcc_sel_o(vcc), .card_active_o(active), .clock_park_select_o(park), .view_select_o(view),
    .warm_reset_o(warm), .host_io_pin_i(host_pin), .host_io_pin_o(h_o), .host_io_pin_oe_n_o(h_oe_n),
    .card_io_pin_i(card_pin), .card_io_pin_o(c_o), .card_io_pin_oe_n_o(c_oe_n));
  host_port_model host_u (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
    .rd_o(rd), .wdata_o(wdata));
  // byte compare, unknown never matches
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_st(input logic [7:0] exp);
    host_u.rd(SLOT_REG0_ADDR, d);
    chk("status", exp, d);
  endtask
  task automatic w0(input logic [7:0] v);
    host_u.wr(SLOT_REG0_ADDR, v);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // 50 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // hang guard, run is a few hundred cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish;
    end
  end
  // main sequence
  initial begin
    rst_i = 1'b1;
    {present, early, mute, ovl, sup, fback, sbit, sync} = 16'h0000;
    host_drv = 2'h3;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    waitc(8);
    rst_i = 1'b0;
    waitc(2);
    chk("irq", 8'h00, {7'h00, irq_n});
    rd_st(8'h00);
    host_u.wr(PAGE_SEL_ADDR, 8'h01);
    rd_st(8'h08);
    rd_st(8'h00);
    host_u.wr(PAGE_SEL_ADDR, 8'h02);
    rd_st(8'h08);
    host_u.wr(PAGE_SEL_ADDR, 8'h01);
    waitc(2);
    chk("irq", 8'h01, {7'h00, irq_n});
    w0(8'h01);
    waitc(4);
    chk("active", 8'h00, {7'h00, active[0]});
    present[0] = 1'b1;
    waitc(3);
    rd_st(8'h03);
    rd_st(8'h01);
    // each supply code, then a locked attempt to change it
    for (int i = 0; i < 3; i++) begin
      w0(vset[i]);
      waitc(4);
      chk("vcc", {6'h00, vexp[i]}, {6'h00, vcc[1:0]});
      w0(vset[i] ^ 8'h84);
      waitc(2);
      chk("vcc lock", {6'h00, vexp[i]}, {6'h00, vcc[1:0]});
      rd_st(8'h81);
      w0(8'h00);
      waitc(6);
      chk("vcc off", 8'h00, {6'h00, vcc[1:0]});
    end
    w0(8'h01);
    waitc(4);
    w0(8'h03);
    waitc(2);
    chk("warm", 8'h01, {7'h00, warm[0]});
    sbit[0] = 1'b1;
    waitc(1);
    sbit[0] = 1'b0;
    waitc(2);
    chk("warm", 8'h00, {7'h00, warm[0]});
    w0(8'h03);
    waitc(2);
    mute[0] = 1'b1;
    waitc(1);
    mute[0] = 1'b0;
    waitc(2);
    chk("warm", 8'h00, {7'h00, warm[0]});
    rd_st(8'hA1);
    // early answer in the very cycle of a status read
    fork
      host_u.rd(SLOT_REG0_ADDR, d);
      begin
        @(negedge sys_clk_i);
        early[0] = 1'b1;
        @(negedge sys_clk_i);
        early[0] = 1'b0;
      end
    join
    rd_st(8'hC1);
    rd_st(8'h81);
    {ovl[0], sup[0]} = 2'h3;
    waitc(1);
    {ovl[0], sup[0]} = 2'h0;
    waitc(4);
    chk("irq", 8'h00, {7'h00, irq_n});
    rd_st(8'h19);
    rd_st(8'h01);
    fback[0] = 1'b1;
    waitc(2);
    rd_st(8'h05);
    fback[0] = 1'b0;
    waitc(2);
    rd_st(8'h01);
    w0(8'h40); // only slot 1 io is ever connected
    host_drv[0] = 1'b0;
    waitc(3);
    chk("card io", 8'h00, {7'h00, c_oe_n[0]});
    host_drv[0] = 1'b1;
    w0(8'h00);
    waitc(3);
    chk("card io", 8'h01, {7'h00, c_oe_n[0]});
    w0(8'h08);
    waitc(2);
    chk("park", 8'h01, {7'h00, park[0]});
    w0(8'h00);
    sync[0] = 1'b1;
    w0(8'h01);
    waitc(4);
    w0(8'h09);
    waitc(2);
    chk("park lock", 8'h00, {7'h00, park[0]});
    w0(8'h00);
    waitc(6);
    sync[0] = 1'b0;
    for (int k = 0; k < 4; k++) begin
      w0(8'(k << 4));
      waitc(1);
      chk("view", 8'(k), {6'h00, view[1:0]});
    end
    host_u.wr(PAGE_SEL_ADDR, 8'h02);
    w0(8'h20);
    host_u.wr(PAGE_SEL_ADDR, 8'h03);
    w0(8'h10);
    waitc(1);
    chk("view 2", 8'h02, {6'h00, view[3:2]});
    rd_st(8'h00);
    tally_and_finish;
  end
endmodule // testbench
bind card_slot_control_status slot_chk #(.NUM_SLOTS(NUM_SLOTS), .ACT_CYCLES(ACT_CYCLES),
  .DEACT_CYCLES(DEACT_CYCLES)) chk_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .interrupt_out_n_o(interrupt_out_n_o), .card_inserted_level_i(card_inserted_level_i),
  .card_start_bit_i(card_start_bit_i), .sync_mode_i(sync_mode_i), .vcc_sel_o(vcc_sel_o),
  .card_active_o(card_active_o), .clock_park_select_o(clock_park_select_o), .view_select_o(view_select_o),
  .warm_reset_o(warm_reset_o), .card_io_pin_oe_n_o(card_io_pin_oe_n_o));
